// File: hw/power_factor_pwm_sequencer.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module power_factor_pwm_sequencer
	import pfc_pwm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] duty_cmd,
	input  wire logic        fault_in,
	output logic             gate_pwm,
	output logic             adc_trigger,
	output logic             irq
);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic [15:0] freq_reg, tmin_reg, dead_reg, shd_reg;
	logic        run_reg;
	evt_t        stat_reg, mask_reg, evt_next;
	seq_t        state_reg;
	logic [31:0] rd_data;
	logic        rd_err;
	logic        wr_en;
	logic [9:0]  idx;

	assign idx   = paddr[11:2];
	assign wr_en = psel & penable & pready & pwrite;

	// read decode; misaligned or unmapped answers with pslverr
	always_comb begin
		rd_data = '0;
		rd_err  = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			rd_err = 1'b1;
		end else if (idx == IDX_FREQ) begin
			rd_data[15:0] = freq_reg;
		end else if (idx == IDX_TMIN) begin
			rd_data[15:0] = tmin_reg;
		end else if (idx == IDX_DEAD) begin
			rd_data[15:0] = dead_reg;
		end else if (idx == IDX_SHD) begin
			rd_data[15:0] = shd_reg;
		end else if (idx == IDX_STATE) begin
			rd_data[15:0] = state_code(state_reg);
		end else if (idx == IDX_RUN) begin
			rd_data[0] = run_reg;
		end else if (idx == IDX_ISTAT) begin
			rd_data[1:0] = stat_reg;
		end else if (idx == IDX_IMASK) begin
			rd_data[1:0] = mask_reg;
		end else begin
			rd_err = 1'b1;
		end
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & rd_err;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= rd_data;
			end
		end
	end

	// writable settings; dead time is stored only, never used
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_reg <= FREQ_RST;
			tmin_reg <= ZERO_RST;
			dead_reg <= ZERO_RST;
			shd_reg  <= ZERO_RST;
			run_reg  <= 1'b0;
			mask_reg <= '0;
		end else if (wr_en && paddr[1:0] == 2'b00) begin
			if (idx == IDX_FREQ) freq_reg <= pwdata[15:0];
			if (idx == IDX_TMIN) tmin_reg <= pwdata[15:0];
			if (idx == IDX_DEAD) dead_reg <= pwdata[15:0];
			if (idx == IDX_SHD) shd_reg <= pwdata[15:0];
			if (idx == IDX_RUN) run_reg <= pwdata[0];
			if (idx == IDX_IMASK) mask_reg <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= '0;
			irq      <= 1'b0;
		end else begin
			if (wr_en && idx == IDX_ISTAT && paddr[1:0] == 2'b00) begin
				stat_reg <= (stat_reg & ~evt_t'(pwdata[1:0])) | evt_next;
			end else begin
				stat_reg <= stat_reg | evt_next;
			end
			irq <= |(stat_reg & mask_reg);
		end
	end

	// ----------------------------------------
	// fault pin synchroniser and 96 MHz step enable
	// ----------------------------------------
	logic [2:0] fsync_reg;
	logic       fault_lvl_reg;
	logic [7:0] acc_reg, acc_next;
	logic       tick_reg;

	// a change counts only once the second and third stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsync_reg     <= '0;
			fault_lvl_reg <= 1'b0;
		end else begin
			fsync_reg <= {fsync_reg[1:0], fault_in};
			if (fsync_reg[1] == fsync_reg[2]) fault_lvl_reg <= fsync_reg[2];
		end
	end

	// fractional divider: 96 steps every 125 clocks, jitter one clock
	assign acc_next = acc_reg + TICK_ADD;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg  <= '0;
			tick_reg <= 1'b0;
		end else if (acc_next >= TICK_MOD) begin
			acc_reg  <= acc_next - TICK_MOD;
			tick_reg <= 1'b1;
		end else begin
			acc_reg  <= acc_next;
			tick_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// period divider: PERIOD_NUM / setting, serial restoring
	// ----------------------------------------
	logic [15:0] period_reg, den_reg, last_freq_reg;
	logic [19:0] rem_reg, quo_reg, shifted;
	logic [4:0]  dcnt_reg;
	logic        busy_reg, div_done;

	assign shifted  = {rem_reg[18:0], quo_reg[19]};
	assign div_done = busy_reg && dcnt_reg == 5'h00;

	// restarts whenever the setting differs from the last one divided
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_reg    <= PERIOD_SAT;
			den_reg       <= '0;
			last_freq_reg <= '0;
			rem_reg       <= '0;
			quo_reg       <= '0;
			dcnt_reg      <= '0;
			busy_reg      <= 1'b0;
		end else if (div_done) begin
			busy_reg   <= 1'b0;
			period_reg <= (quo_reg > 20'(PERIOD_SAT)) ? PERIOD_SAT : quo_reg[15:0];
		end else if (busy_reg) begin
			dcnt_reg <= dcnt_reg - 5'h01;
			if (shifted >= 20'(den_reg)) begin
				rem_reg <= shifted - 20'(den_reg);
				quo_reg <= {quo_reg[18:0], 1'b1};
			end else begin
				rem_reg <= shifted;
				quo_reg <= {quo_reg[18:0], 1'b0};
			end
		end else if (freq_reg != last_freq_reg || period_reg == PERIOD_SAT) begin
			busy_reg      <= 1'b1;
			last_freq_reg <= freq_reg;
			den_reg       <= freq_reg;
			rem_reg       <= '0;
			quo_reg       <= PERIOD_NUM;
			dcnt_reg      <= DIV_STEPS;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic [15:0] ofs_cnt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_POWER_ON;
			ofs_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_POWER_ON: state_reg <= ST_STOP;
				ST_STOP: begin
					ofs_cnt_reg <= '0;
					if (run_reg) state_reg <= ST_OFFSET;
				end
				ST_OFFSET: begin
					if (fault_lvl_reg) begin
						state_reg <= ST_FAULT;
					end else if (!run_reg) begin
						state_reg <= ST_STOP;
					end else if (tick_reg) begin
						ofs_cnt_reg <= ofs_cnt_reg + 16'h0001;
						if (ofs_cnt_reg == OFS_TICKS - 16'h0001) state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (fault_lvl_reg) state_reg <= ST_FAULT;
					else if (!run_reg) state_reg <= ST_STOP;
				end
				default: begin
					if (!run_reg) state_reg <= ST_STOP;
				end
			endcase
		end
	end

	// events fire on entry to running and to fault
	always_comb begin
		evt_next         = '0;
		evt_next.running = state_reg == ST_OFFSET && run_reg && !fault_lvl_reg
			&& tick_reg && ofs_cnt_reg == OFS_TICKS - 16'h0001;
		evt_next.fault   = (state_reg == ST_OFFSET || state_reg == ST_RUN)
			&& fault_lvl_reg;
	end

	// ----------------------------------------
	// center-aligned pwm with minimum off time
	// ----------------------------------------
	logic [15:0] cnt_reg, cmp_reg, moff, cmp_lim, duty_lim;
	logic        up_reg, gate_d_reg, run_on;

	assign run_on   = state_reg == ST_RUN;
	assign moff     = (tmin_reg > period_reg) ? period_reg : tmin_reg;
	assign cmp_lim  = period_reg - moff;
	assign duty_lim = (duty_cmd > cmp_lim) ? cmp_lim : duty_cmd;

	// compare reloads only at the valley while running, so the off time around the peak is never cut short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			cmp_reg <= '0;
			up_reg  <= 1'b1;
		end else if (!run_on) begin
			cnt_reg <= '0;
			up_reg  <= 1'b1;
			cmp_reg <= duty_lim;
		end else if (tick_reg) begin
			if (up_reg) begin
				if (cnt_reg >= period_reg) begin
					up_reg  <= 1'b0;
					cnt_reg <= cnt_reg - 16'h0001;
				end else begin
					cnt_reg <= cnt_reg + 16'h0001;
				end
			end else if (cnt_reg == 16'h0000) begin
				up_reg  <= 1'b1;
				cnt_reg <= 16'h0001;
				cmp_reg <= duty_lim;
			end else begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_pwm   <= 1'b0;
			gate_d_reg <= 1'b0;
		end else begin
			gate_pwm   <= run_on && cnt_reg < cmp_reg;
			gate_d_reg <= gate_pwm;
		end
	end

	// ----------------------------------------
	// adc sample trigger after each gate edge that the next edge does not overtake
	// ----------------------------------------
	logic [15:0] dly_cnt_reg, shd_eff;
	logic        dly_act_reg;

	assign shd_eff = (shd_reg > SHD_MAX) ? SHD_MAX : shd_reg;

	// a new edge restarts the wait; delays longer than the time to the next edge drop one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_reg <= '0;
			dly_act_reg <= 1'b0;
			adc_trigger <= 1'b0;
		end else begin
			adc_trigger <= 1'b0;
			if (gate_pwm != gate_d_reg) begin
				dly_cnt_reg <= '0;
				dly_act_reg <= 1'b1;
			end else if (dly_act_reg) begin
				if (dly_cnt_reg >= shd_eff) begin
					adc_trigger <= 1'b1;
					dly_act_reg <= 1'b0;
				end else if (tick_reg) begin
					dly_cnt_reg <= dly_cnt_reg + 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [19:0] exp_period;
	assign exp_period = (last_freq_reg == 16'h0000) ? 20'(PERIOD_SAT)
		: PERIOD_NUM / 20'(last_freq_reg);

	sequence s_start_cmd;
		state_reg == ST_STOP && wr_en && idx == IDX_RUN && pwdata[0];
	endsequence
	sequence s_fault_seen;
		state_reg == ST_RUN && fault_lvl_reg;
	endsequence

	a_state_code_range: assert property (state_code(state_reg) <= 16'h0005)
		else $error("state code above five");
	a_start_offset: assert property (s_start_cmd |-> ##2 state_reg == ST_OFFSET)
		else $error("start did not enter offset measurement");
	a_stop_return: assert property ((state_reg == ST_RUN && !run_reg && !fault_lvl_reg)
		|=> state_reg == ST_STOP)
		else $error("stop command ignored");
	a_fault_entry: assert property (s_fault_seen |=> state_reg == ST_FAULT)
		else $error("fault not entered");
	a_period_value: assert property (div_done |=> period_reg ==
		((exp_period > 20'(PERIOD_SAT)) ? PERIOD_SAT : exp_period[15:0]))
		else $error("period count wrong");
	a_min_off_cmp: assert property (run_on && tick_reg && !up_reg && cnt_reg == 16'h0000
		|=> cmp_reg + $past(moff) <= $past(period_reg))
		else $error("minimum off time violated");
	a_gate_needs_run: assert property (gate_pwm |-> $past(run_on))
		else $error("gate active outside running");
	a_trig_delay: assert property ($rose(adc_trigger) |-> $past(dly_act_reg)
		&& $past(dly_cnt_reg) >= $past(shd_eff) && $past(shd_eff) <= SHD_MAX)
		else $error("adc trigger without delay elapsed");

endmodule

// File: hw/pfc_pwm_pkg.sv
package pfc_pwm_pkg;

	// ----------------------------------------
	// register indices, byte address is index times four
	// ----------------------------------------
	localparam logic [9:0] IDX_FREQ  = 10'h003;
	localparam logic [9:0] IDX_TMIN  = 10'h004;
	localparam logic [9:0] IDX_DEAD  = 10'h005;
	localparam logic [9:0] IDX_SHD   = 10'h006;
	localparam logic [9:0] IDX_STATE = 10'h051;
	localparam logic [9:0] IDX_RUN   = 10'h052;
	localparam logic [9:0] IDX_ISTAT = 10'h060;
	localparam logic [9:0] IDX_IMASK = 10'h061;

	// ----------------------------------------
	// reset values and limits
	// ----------------------------------------
	localparam logic [15:0] FREQ_RST = 16'h1770;
	localparam logic [15:0] ZERO_RST = 16'h0000;
	localparam logic [15:0] SHD_MAX  = 16'h03C0;
	localparam logic [15:0] OFS_TICKS = 16'h0400;
	localparam logic [15:0] PERIOD_SAT = 16'hFFFF;
	// 96 MHz / (2 * 100 Hz per step)
	localparam logic [19:0] PERIOD_NUM = 20'h75300;
	localparam logic [4:0]  DIV_STEPS  = 5'h14;

	// ----------------------------------------
	// count base: 96 MHz steps from the 125 MHz clock
	// ----------------------------------------
	localparam int CLK_HZ  = 125_000_000;
	localparam int BASE_HZ = 96_000_000;
	localparam logic [7:0] TICK_ADD = 8'(BASE_HZ / 1_000_000);
	localparam logic [7:0] TICK_MOD = 8'(CLK_HZ / 1_000_000);

	typedef enum logic [2:0] {
		ST_POWER_ON, ST_STOP, ST_OFFSET, ST_RUN, ST_FAULT
	} seq_t;

	typedef struct packed {
		logic running;
		logic fault;
	} evt_t;

	function automatic logic [15:0] state_code(input seq_t s);
		case (s)
			ST_STOP:   state_code = 16'h0001;
			ST_OFFSET: state_code = 16'h0002;
			ST_RUN:    state_code = 16'h0004;
			ST_FAULT:  state_code = 16'h0005;
			default:   state_code = 16'h0000;
		endcase
	endfunction

endpackage

// File: tb/switch_stage_model.sv
`timescale 1ns/1ns
module switch_stage_model(
	input  wire logic pclk,
	input  wire logic gate_pwm,
	input  wire logic adc_trigger,
	input  wire logic trip,
	output logic      fault_in,
	output int        period_clks,
	output int        trig_lag,
	output int        gate_edges
);
	logic prev_gate;
	int   cnt;
	int   lag;
	// desaturation trip of the switch, raised only when the bench commands it
	assign fault_in = trip;
	initial begin
		prev_gate = 1'b0;
		{cnt, lag, period_clks, trig_lag, gate_edges} = '0;
	end
	// period between rising gate edges and gate-edge-to-sample lag, in clocks
	always @(posedge pclk) begin
		prev_gate <= gate_pwm;
		cnt <= cnt + 1;
		lag <= lag + 1;
		if (gate_pwm !== prev_gate) begin
			lag <= 0;
			gate_edges <= gate_edges + 1;
		end
		if (gate_pwm && !prev_gate) begin
			period_clks <= cnt;
			cnt <= 1;
		end
		if (adc_trigger)
			trig_lag <= lag;
	end
endmodule

// File: tb/power_factor_pwm_sequencer_bench.sv
`timescale 1ns/1ns
module power_factor_pwm_sequencer_bench;
	import pfc_pwm_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trip = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] duty_cmd = 16'h0000;
	logic        pready, pslverr, fault_in, gate_pwm, adc_trigger, irq, err;
	int          period_clks, trig_lag, gate_edges, lag0, edges;
	int          mismatches = 0, total_checks = 0, seed = 36;
	int          exp_reg[int];

	always #4 pclk = ~pclk;

	power_factor_pwm_sequencer u_power_factor_pwm_sequencer(.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .duty_cmd,
		.fault_in, .gate_pwm, .adc_trigger, .irq);
	switch_stage_model u_switch_stage_model(.pclk, .gate_pwm, .adc_trigger, .trip,
		.fault_in, .period_clks, .trig_lag, .gate_edges);

	task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// ----------------------------------------
	// apb master; the register model follows accepted writes to the five registers it holds
	// ----------------------------------------
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			mismatches++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && err === 1'b0 && exp_reg.exists(idx))
			exp_reg[idx] = d[15:0];
	endtask

	task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 32'h0);
		chk(exp, rd, what);
	endtask

	// bounded poll, the offset measurement takes about 1334 clocks
	task automatic wait_state(input logic [31:0] s);
		int n;
		n = 0;
		do begin
			apb(1'b0, IDX_STATE, 32'h0);
			n++;
		end while (rd !== s && n < 600);
	endtask

	task automatic end_of_test;
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#400000;
		mismatches++;
		end_of_test();
	end

	initial begin
		exp_reg[IDX_FREQ] = 16'h1770;
		exp_reg[IDX_TMIN] = 0;
		exp_reg[IDX_DEAD] = 0;
		exp_reg[IDX_SHD] = 0;
		exp_reg[IDX_RUN] = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (exp_reg[i]) rchk(i, exp_reg[i], "reset value");
		rchk(IDX_STATE, 32'h1, "state after reset");
		// random settings; dead time always zero, sample delay kept in range
		repeat (4) begin
			duty_cmd <= 16'($random(seed));
			apb(1'b1, IDX_FREQ, 1 + {$random(seed)} % 1000);
			apb(1'b1, IDX_TMIN, $random(seed) & 32'hFFFF);
			apb(1'b1, IDX_SHD, {$random(seed)} % 961);
			apb(1'b1, IDX_DEAD, 32'h0);
			foreach (exp_reg[i]) rchk(i, exp_reg[i], "readback");
		end
		apb(1'b1, IDX_STATE, 32'h3);
		rchk(IDX_STATE, 32'h1, "read-only state");
		apb(1'b0, 10'h0FF, 32'h0);
		chk(1'b1, err, "unmapped error");
		// 250 kHz: 192-step period, half duty, zero sample delay
		duty_cmd <= 16'h0060;
		apb(1'b1, IDX_FREQ, 32'h09C4);
		apb(1'b1, IDX_TMIN, 32'h0);
		apb(1'b1, IDX_SHD, 32'h0);
		apb(1'b1, IDX_IMASK, 32'h3);
		apb(1'b1, IDX_RUN, 32'h1);
		rchk(IDX_STATE, 32'h2, "offset state");
		chk(1'b0, gate_pwm, "gate in offset");
		wait_state(32'h4);
		chk(32'h4, rd, "running state");
		rchk(IDX_ISTAT, 32'h2, "running event");
		chk(1'b1, irq, "irq raised");
		apb(1'b1, IDX_ISTAT, 32'h2);
		rchk(IDX_ISTAT, 32'h0, "status cleared");
		chk(1'b0, irq, "irq cleared");
		repeat (1100) @(posedge pclk);
		chk(2 * (96000000 / (2 * 250000)) * 125 / 96, period_clks, "period");
		lag0 = trig_lag;
		apb(1'b1, IDX_SHD, 32'h60);
		repeat (600) @(posedge pclk);
		chk(1'b1, (trig_lag - lag0) inside {[124:126]}, "trigger delay");
		// off time above the period leaves no room for any pulse
		apb(1'b1, IDX_TMIN, 32'hC8);
		repeat (600) @(posedge pclk);
		edges = gate_edges;
		repeat (600) @(posedge pclk);
		chk(edges, gate_edges, "gate held off");
		apb(1'b1, IDX_TMIN, 32'h0);
		apb(1'b1, IDX_IMASK, 32'h2);
		trip <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(1'b0, gate_pwm, "gate on fault");
		chk(1'b0, irq, "fault masked");
		rchk(IDX_STATE, 32'h5, "fault state");
		apb(1'b1, IDX_IMASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk(1'b1, irq, "fault unmasked");
		trip <= 1'b0;
		apb(1'b1, IDX_RUN, 32'h0);
		rchk(IDX_STATE, 32'h1, "stopped");
		// restart, then stop straight out of running
		apb(1'b1, IDX_RUN, 32'h1);
		wait_state(32'h4);
		chk(32'h4, rd, "restarted");
		apb(1'b1, IDX_RUN, 32'h0);
		rchk(IDX_STATE, 32'h1, "stopped from running");
		chk(1'b0, gate_pwm, "gate after stop");
		end_of_test();
	end
endmodule
